// ---- interrupt_priority_enable_ctrl.sv ----
/*
 * Interrupt controller front end: NMI and six external request pins with
 * selectable sensing, eleven priority registers, per-line enables,
 * arbitration, vector generation and routing to a transfer controller.
 * Assumes synchronous pin inputs, an APB master, and a CPU core that
 * pulses cpu_ack when it starts exception handling for the presented
 * request.
 */
`include "intc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module interrupt_priority_enable_ctrl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Request pins and internal module requests
  input wire logic nmi_pin,
  input wire logic [5:0] ext_request_line_n,
  input wire logic [15:0] int_req,
  // CPU core
  input wire logic cpu_i_mask,
  input wire logic [2:0] cpu_mask_level,
  input wire logic cpu_ack,
  output intc_pkg::cpu_req_t cpu_req,
  // Data transfer controller
  output logic [5:0] xfer_start,
  input wire logic [5:0] xfer_ack,
  // Controller event interrupt
  output logic irq
);

  // ==========================================================
  // Storage
  logic [7:0] system_control_reg_q;
  logic [7:0] ext_request_enable_reg_q;
  logic [7:0] sense_select_low_reg_q;
  logic [7:0] sense_select_high_reg_q;
  logic [5:0] flag_q, flag_d;
  logic [5:0] armed_q, armed_d;
  logic [6:0] evt_stat_q, evt_en_q;
  logic [5:0] route_q;
  logic [7:0] prio_q [0:`NUM_PRIO_REGS-1];
  logic [5:0] line_prev_q;
  logic nmi_prev_q, nmi_flag_q, started_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  intc_pkg::cpu_req_t cpu_req_q;
  logic [4:0] src_q;

  // ==========================================================
  // APB decode
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en = access_ph && pwrite;
  wire rd_en = access_ph && !pwrite;
  wire aligned = (paddr[1:0] == 2'b00);
  wire in_prio = aligned && (paddr >= `OFS_PRIO_FIRST)
    && (paddr <= `OFS_PRIO_LAST);
  wire [7:0] prio_ofs = paddr - `OFS_PRIO_FIRST;
  wire [3:0] prio_idx = prio_ofs[5:2];
  wire hit_sys = aligned && (paddr == `OFS_SYSTEM_CONTROL);
  wire hit_enable = aligned && (paddr == `OFS_EXT_ENABLE);
  wire hit_isl = aligned && (paddr == `OFS_SENSE_LOW);
  wire hit_ish = aligned && (paddr == `OFS_SENSE_HIGH);
  wire hit_status = aligned && (paddr == `OFS_EXT_STATUS);
  wire hit_est = aligned && (paddr == `OFS_EVT_STATUS);
  wire hit_ecl = aligned && (paddr == `OFS_EVT_CLEAR);
  wire hit_een = aligned && (paddr == `OFS_EVT_ENABLE);
  wire hit_rte = aligned && (paddr == `OFS_XFER_ROUTE);
  wire [7:0] wdat = pwdata[7:0];
  logic [7:0] rd_byte;
  logic rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    if (hit_sys) begin
      rd_byte = system_control_reg_q;
    end else if (hit_enable) begin
      rd_byte = ext_request_enable_reg_q;
    end else if (hit_isl) begin
      rd_byte = sense_select_low_reg_q;
    end else if (hit_ish) begin
      rd_byte = sense_select_high_reg_q;
    end else if (hit_status) begin
      rd_byte = {2'b00, flag_q};
    end else if (hit_est) begin
      rd_byte = {1'b0, evt_stat_q};
    end else if (hit_ecl) begin
      rd_byte = 8'h00;
    end else if (hit_een) begin
      rd_byte = {1'b0, evt_en_q};
    end else if (hit_rte) begin
      rd_byte = {2'b00, route_q};
    end else if (in_prio) begin
      rd_byte = prio_q[prio_idx] & `PRIO_RD_MASK;
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  // The read word is captured in the setup cycle so that the read-arming
  // of status flags sees exactly the value software receives.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup_ph) begin
      prdata_q <= {24'h00_0000, rd_byte};
      pslverr_q <= !rd_hit;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access_ph && pslverr_q;
  wire wr_ok = wr_en && !pslverr_q;

  // ==========================================================
  // Control registers
  // mode field in system control
  wire [1:0] mode_sel = system_control_reg_q[`MODE_SEL_LSB +: 2];
  wire mode2 = (mode_sel == intc_pkg::MODE_2);
  wire nmi_rising = system_control_reg_q[`NMI_RISING_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_reg_q <= 8'h00;
      ext_request_enable_reg_q <= `EXT_ENABLE_RESET;
      sense_select_low_reg_q <= 8'h00;
      sense_select_high_reg_q <= 8'h00;
      evt_en_q <= 7'h00;
      route_q <= 6'h00;
    end else if (wr_ok) begin
      if (hit_sys) begin
        system_control_reg_q <= wdat & `SYSCTL_WR_MASK;
      end
      if (hit_enable) begin
        ext_request_enable_reg_q <= wdat;
      end
      if (hit_isl) begin
        sense_select_low_reg_q <= wdat;
      end
      if (hit_ish) begin
        sense_select_high_reg_q <= wdat & `SENSE_HIGH_MASK;
      end
      if (hit_een) begin
        evt_en_q <= wdat[6:0];
      end
      if (hit_rte) begin
        route_q <= wdat[5:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int r = 0; r < `NUM_PRIO_REGS; r++) begin
        prio_q[r] <= `PRIO_RESET;
      end
    end else if (wr_ok && in_prio) begin
      prio_q[prio_idx] <= wdat & `PRIO_RD_MASK;
    end
  end

  // ==========================================================
  // Pin sensing
  wire [11:0] sense_all = {sense_select_high_reg_q[3:0],
    sense_select_low_reg_q};
  logic [5:0] line_set;

  // Edge history is only trusted after the first cycle out of reset,
  // so the reset value of the history cannot fake an edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_q <= 6'h3F;
      nmi_prev_q <= 1'b0;
      started_q <= 1'b0;
    end else begin
      line_prev_q <= ext_request_line_n;
      nmi_prev_q <= nmi_pin;
      started_q <= 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `NUM_EXT; g++) begin : gen_sense
      wire [1:0] sel = sense_all[2*g +: 2];
      wire cur = ext_request_line_n[g];
      wire fall = started_q && line_prev_q[g] && !cur;
      wire rise = started_q && !line_prev_q[g] && cur;
      assign line_set[g] = ((sel == intc_pkg::SENSE_LOW) && !cur)
        || ((sel == intc_pkg::SENSE_FALL) && fall)
        || ((sel == intc_pkg::SENSE_RISE) && rise)
        || ((sel == intc_pkg::SENSE_BOTH) && (fall || rise));
    end
  endgenerate

  wire nmi_edge = started_q && (nmi_rising ? (!nmi_prev_q && nmi_pin)
    : (nmi_prev_q && !nmi_pin));

  // ==========================================================
  // Pending flags
  wire acked = cpu_ack && cpu_req_q.req;
  wire ack_ext = acked && !cpu_req_q.nmi && (src_q < 5'd6);
  wire [5:0] ack_mask = ack_ext ? (6'h01 << src_q[2:0]) : 6'h00;
  wire status_wr = wr_ok && hit_status;
  wire status_rd = rd_en && hit_status;

  // read 1, write 0, exception handling, or transfer ack clears; set wins
  always_comb begin
    flag_d = flag_q;
    armed_d = armed_q;
    if (status_rd) begin
      armed_d = armed_q | prdata_q[5:0];
    end
    if (status_wr) begin
      flag_d = flag_q & ~(armed_q & ~wdat[5:0]);
      armed_d = armed_q & wdat[5:0];
    end
    flag_d = (flag_d & ~ack_mask & ~xfer_ack) | line_set;
    armed_d = armed_d & flag_d;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 6'h00;
      armed_q <= 6'h00;
      nmi_flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      armed_q <= armed_d;
      nmi_flag_q <= nmi_edge || (nmi_flag_q && !(acked && cpu_req_q.nmi));
    end
  end

  // ==========================================================
  // Arbitration
  // enable gates each line
  wire [5:0] ext_live = flag_q & ext_request_enable_reg_q[5:0];
  // routed lines start the transfer controller
  assign xfer_start = ext_live & route_q;
  wire [21:0] cand = {int_req, ext_live & ~route_q};
  logic [2:0] src_lvl [0:`NUM_SRC-1];

  generate
    for (g = 0; g < `NUM_SRC; g++) begin : gen_lvl
      assign src_lvl[g] = prio_q[g/2][(g%2)*4 +: 3];
    end
  endgenerate

  logic best_found;
  logic [4:0] best_idx;
  logic [2:0] best_lvl;
  logic [2:0] lvl;

  // highest level wins, lower index on a tie
  always_comb begin
    best_found = 1'b0;
    best_idx = 5'd0;
    best_lvl = 3'd0;
    lvl = 3'd0;
    for (int s = 0; s < `NUM_SRC; s++) begin
      lvl = mode2 ? src_lvl[s] : 3'd0;
      if (cand[s] && (!best_found || (lvl > best_lvl))) begin
        best_found = 1'b1;
        best_idx = 5'(s);
        best_lvl = lvl;
      end
    end
  end

  // Mode 0 uses only the CPU mask bit; mode 2 compares against the mask
  // level, so a level-0 source can never interrupt in mode 2.
  wire mask_pass = mode2 ? (best_lvl > cpu_mask_level) : !cpu_i_mask;
  wire [6:0] best_vec = (best_idx < 5'd6)
    ? (`VEC_EXT_BASE + {2'b00, best_idx})
    : (`VEC_INT_BASE + {2'b00, best_idx - 5'd6});
  intc_pkg::cpu_req_t next_req;

  always_comb begin
    next_req = '0;
    if (nmi_flag_q) begin
      // NMI never masked, above all levels
      next_req.req = 1'b1;
      next_req.nmi = 1'b1;
      next_req.vector = `VEC_NMI;
      next_req.level = 3'h7;
    end else if (best_found && mask_pass) begin
      next_req.req = 1'b1;
      next_req.vector = best_vec;
      next_req.level = best_lvl;
    end
  end

  // The request dropped for one cycle after an ack so the CPU never sees
  // a stale vector for the source it just took.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_req_q <= '0;
      src_q <= 5'd0;
    end else if (acked) begin
      cpu_req_q <= '0;
    end else begin
      cpu_req_q <= next_req;
      src_q <= best_idx;
    end
  end

  assign cpu_req = cpu_req_q;

  // ==========================================================
  // Controller event interrupt
  wire [6:0] evt_set = {nmi_edge, line_set & ~flag_q};
  wire [6:0] evt_clr = (wr_ok && hit_ecl) ? wdat[6:0] : 7'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat_q <= 7'h00;
      irq <= 1'b0;
    end else begin
      evt_stat_q <= (evt_stat_q & ~evt_clr) | evt_set;
      irq <= |(((evt_stat_q & ~evt_clr) | evt_set) & evt_en_q);
    end
  end

endmodule

`default_nettype wire

// ---- intc_defs.svh ----
/*
 * Offsets, field positions, reset values and codes for the interrupt
 * priority and enable controller.
 * Assumes an APB slave with byte addresses and 32-bit aligned words.
 */
`ifndef INTC_DEFS_SVH
`define INTC_DEFS_SVH

// ==========================================================
// Register byte offsets
`define OFS_SYSTEM_CONTROL 8'h00
`define OFS_EXT_ENABLE 8'h04
`define OFS_SENSE_LOW 8'h08
`define OFS_SENSE_HIGH 8'h0C
`define OFS_EXT_STATUS 8'h10
`define OFS_EVT_STATUS 8'h14
`define OFS_EVT_CLEAR 8'h18
`define OFS_EVT_ENABLE 8'h1C
`define OFS_XFER_ROUTE 8'h20
`define OFS_PRIO_FIRST 8'h40
`define OFS_PRIO_LAST 8'h68

// ==========================================================
// Field positions and masks
`define MODE_SEL_LSB 4
`define NMI_RISING_BIT 0
`define SYSCTL_WR_MASK 8'h31
`define PRIO_RD_MASK 8'h77
`define PRIO_RESET 8'h77
`define EXT_ENABLE_RESET 8'h00
`define SENSE_HIGH_MASK 8'h0F
`define ROUTE_MASK 8'h3F
`define EVT_MASK 8'h7F

// ==========================================================
// Sizes and vector numbers
`define NUM_EXT 6
`define NUM_INT 16
`define NUM_SRC 22
`define NUM_PRIO_REGS 11
`define VEC_NMI 7'h07
`define VEC_EXT_BASE 7'h10
`define VEC_INT_BASE 7'h18
`define NMI_EVT_BIT 6

`endif

// ---- intc_pkg.sv ----
/*
 * Types shared by the interrupt controller and its users.
 * Assumes intc_defs.svh supplies all numeric constants.
 */
package intc_pkg;

  // ==========================================================
  // Interrupt control modes, as held in the mode-select field.
  typedef enum logic [1:0] {
    MODE_0 = 2'b00,
    MODE_2 = 2'b10
  } ctrl_mode_t;

  // ==========================================================
  // Per-line sense selection.
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_FALL = 2'b01,
    SENSE_RISE = 2'b10,
    SENSE_BOTH = 2'b11
  } sense_t;

  // ==========================================================
  // Request presented to the CPU core.
  typedef struct packed {
    logic req;
    logic nmi;
    logic [6:0] vector;
    logic [2:0] level;
  } cpu_req_t;

endpackage

// ---- intc_port_monitor.sv ----
/*
 * Port checker for the interrupt priority and enable controller.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/100ps
`default_nettype none

module intc_port_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // CPU core and transfer controller
  input wire logic cpu_ack,
  input wire intc_pkg::cpu_req_t cpu_req,
  input wire logic [5:0] xfer_start,
  input wire logic irq
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Handshake steps
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable && pready;
  endsequence
  sequence taken_s;
    cpu_req.req && cpu_ack;
  endsequence

  // ==========================================================
  // Assertions
  reset_quiet_a: assert property ($rose(presetn) |->
    cpu_req == '0 && xfer_start == 6'h00 && !irq)
    else $error("outputs not quiet after reset");
  pslverr_phase_a: assert property (
    pslverr |-> psel && penable)
    else $error("error flag outside access");
  unaligned_err_a: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  upper_zero_a: assert property (
    access_s |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  read_stable_a: assert property (
    setup_s ##1 access_s |=> $stable(prdata))
    else $error("read data moved");
  ack_drop_a: assert property (taken_s |=> !cpu_req.req)
    else $error("request held after ack");
  nmi_vector_a: assert property (
    cpu_req.req |-> cpu_req.nmi == (cpu_req.vector == 7'h07))
    else $error("nonmaskable vector mismatch");
  vector_range_a: assert property (
    cpu_req.req && !cpu_req.nmi |->
    cpu_req.vector inside {[7'h10:7'h15], [7'h18:7'h27]})
    else $error("vector out of range");
  route_excl_a: assert property (
    cpu_req.req && cpu_req.vector inside {[7'h10:7'h15]} |->
    !xfer_start[cpu_req.vector[2:0]])
    else $error("routed line sent to cpu");
endmodule

bind interrupt_priority_enable_ctrl intc_port_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cpu_ack(cpu_ack), .cpu_req(cpu_req), .xfer_start(xfer_start),
  .irq(irq));
`default_nettype wire

// ---- cpu_core_model.sv ----
/*
 * Behavioural CPU core: takes each presented request after a chosen
 * number of waiting cycles and logs the vectors it took.
 * Assumes the controller drops its request at the taking edge.
 */
`timescale 1ns/100ps
`default_nettype none

module cpu_core_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Controller side
  input wire intc_pkg::cpu_req_t cpu_req,
  output logic cpu_ack,
  // Bench side
  input wire logic [1:0] hold,
  output logic [3:0][6:0] vec_log,
  output logic [2:0] n_acked
);
  logic [1:0] wait_q;

  // ==========================================================
  // The ack comes no sooner than the edge after the request is seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      wait_q <= 2'h0;
      vec_log <= '0;
      n_acked <= 3'h0;
    end else begin
      if (cpu_ack && cpu_req.req) begin
        vec_log[n_acked[1:0]] <= cpu_req.vector;
        n_acked <= n_acked + 3'h1;
      end
      if (cpu_ack) begin
        cpu_ack <= 1'b0;
        wait_q <= 2'h0;
      end else if (cpu_req.req) begin
        if (wait_q == hold) cpu_ack <= 1'b1;
        else wait_q <= wait_q + 2'h1;
      end else begin
        wait_q <= 2'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- interrupt_priority_enable_ctrl_test.sv ----
/*
 * Self-checking bench for the interrupt priority and enable controller.
 * Assumes intc_defs.svh offsets and a zero-wait APB slave or slower.
 */
`include "intc_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module interrupt_priority_enable_ctrl_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, nmi_pin = 1'b0, cpu_i_mask = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, cpu_ack, irq;
  logic [5:0] pins = 6'h3F, xfer_ack = 6'h00, xfer_start;
  logic [15:0] int_req = 16'h0000;
  logic [2:0] cpu_mask_level = 3'h0, n_acked;
  logic [1:0] hold = 2'h0;
  logic [3:0][6:0] vec_log;
  intc_pkg::cpu_req_t cpu_req;
  int error_cnt = 0, n_checks = 0, cyc = 0;

  interrupt_priority_enable_ctrl dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nmi_pin(nmi_pin), .ext_request_line_n(pins), .int_req(int_req),
    .cpu_i_mask(cpu_i_mask), .cpu_mask_level(cpu_mask_level),
    .cpu_ack(cpu_ack), .cpu_req(cpu_req), .xfer_start(xfer_start),
    .xfer_ack(xfer_ack), .irq(irq));
  cpu_core_model cpu (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req),
    .cpu_ack(cpu_ack), .hold(hold), .vec_log(vec_log), .n_acked(n_acked));

  always #2.5 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The timeout is generous: the whole run needs well under 2000 cycles.
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Values read right after an edge are the ones that edge sampled,
    // so the answer is taken at the edge that completes the transfer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic pulse(input logic [5:0] m);
    pins <= pins & ~m;
    repeat (4) @(posedge pclk);
    pins <= pins | m;
    repeat (4) @(posedge pclk);
  endtask
  task automatic wait_acks(input logic [2:0] k);
    int n;
    n = 0;
    while (n_acked !== k && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n_acked), 32'(k));
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 11; i++) begin
      rd_chk(8'h40 + 8'(4 * i), 32'h77);
    end
    rd_chk(`OFS_EXT_ENABLE, 32'h00);
    rd_chk(`OFS_SYSTEM_CONTROL, 32'h00);
    apb(1'b1, `OFS_PRIO_LAST, 32'hFF);
    rd_chk(`OFS_PRIO_LAST, 32'h77);
    apb(1'b1, `OFS_PRIO_LAST, 32'h25);
    rd_chk(`OFS_PRIO_LAST, 32'h25);
    apb(1'b1, `OFS_EXT_ENABLE, 32'h3F);
    rd_chk(`OFS_EXT_ENABLE, 32'h3F);
    apb(1'b1, `OFS_EXT_ENABLE, 32'h00);
    apb(1'b0, 8'h25, 32'h0);
    chk({31'h0, e}, 32'h1);
  endtask
  // Line 0 runs through all four sense codes with its enable off.
  // A level-sensed flag stays set after the pin returns high, until
  // software clears it.
  task automatic t_sense;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `OFS_SENSE_LOW, 32'(c));
      pins[0] <= 1'b0;
      repeat (4) @(posedge pclk);
      rd_chk(`OFS_EXT_STATUS, {31'h0, c != 2});
      apb(1'b1, `OFS_EXT_STATUS, 32'h0);
      rd_chk(`OFS_EXT_STATUS, {31'h0, c == 0});
      pins[0] <= 1'b1;
      repeat (4) @(posedge pclk);
      rd_chk(`OFS_EXT_STATUS, {31'h0, c != 1});
      apb(1'b1, `OFS_EXT_STATUS, 32'h0);
      chk({31'h0, cpu_req.req}, 32'h0);
    end
  endtask
  task automatic t_irq;
    apb(1'b1, `OFS_SENSE_LOW, 32'h01);
    apb(1'b1, `OFS_EVT_CLEAR, 32'h7F);
    pulse(6'h01);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `OFS_EVT_ENABLE, 32'h01);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`OFS_EVT_STATUS, 32'h01);
    apb(1'b1, `OFS_EVT_CLEAR, 32'h01);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_prio;
    apb(1'b0, `OFS_EXT_STATUS, 32'h0);
    apb(1'b1, `OFS_EXT_STATUS, 32'h0);
    apb(1'b1, `OFS_SYSTEM_CONTROL, 32'h20);
    apb(1'b1, `OFS_PRIO_FIRST, 32'h53);
    apb(1'b1, `OFS_SENSE_LOW, 32'h05);
    cpu_mask_level <= 3'h2;
    apb(1'b1, `OFS_EXT_ENABLE, 32'h03);
    pulse(6'h03);
    wait_acks(3'h2);
    chk(32'(vec_log[0]), 32'h11);
    chk(32'(vec_log[1]), 32'h10);
    cpu_mask_level <= 3'h5;
    pulse(6'h02);
    chk(32'(n_acked), 32'h2);
    cpu_mask_level <= 3'h4;
    hold <= 2'h3;
    wait_acks(3'h3);
    chk(32'(vec_log[2]), 32'h11);
  endtask
  task automatic t_nmi;
    apb(1'b1, `OFS_SYSTEM_CONTROL, 32'h21);
    cpu_mask_level <= 3'h7;
    cpu_i_mask <= 1'b1;
    nmi_pin <= 1'b1;
    wait_acks(3'h4);
    chk(32'(vec_log[3]), 32'h07);
  endtask
  task automatic t_xfer;
    apb(1'b1, `OFS_XFER_ROUTE, 32'h04);
    apb(1'b1, `OFS_SENSE_LOW, 32'h15);
    apb(1'b1, `OFS_EXT_ENABLE, 32'h07);
    cpu_mask_level <= 3'h0;
    pulse(6'h04);
    chk(32'(xfer_start), 32'h04);
    chk(32'(n_acked), 32'h4);
    xfer_ack <= 6'h04;
    @(posedge pclk);
    xfer_ack <= 6'h00;
    repeat (2) @(posedge pclk);
    chk(32'(xfer_start), 32'h00);
  endtask
  // Mode 0 ignores levels: the lower source wins even at level 0, and
  // only the CPU mask bit holds requests back. Internal requests are
  // levels, so the bench drops them once the first one is taken.
  task automatic t_mode0;
    apb(1'b1, `OFS_SYSTEM_CONTROL, 32'h01);
    apb(1'b1, `OFS_PRIO_FIRST + 8'h0C, 32'h00);
    int_req <= 16'h0009;
    repeat (6) @(posedge pclk);
    chk(32'(n_acked), 32'h4);
    cpu_i_mask <= 1'b0;
    wait_acks(3'h5);
    int_req <= 16'h0000;
    chk(32'(vec_log[0]), 32'h18);
    repeat (8) @(posedge pclk);
    chk(32'(n_acked), 32'h5);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_sense();
    t_irq();
    t_prio();
    t_nmi();
    t_xfer();
    t_mode0();
    tally_and_finish();
  end
endmodule
`default_nettype wire
